// *** pkg/ctw_defines.svh ***
// Purpose: Offsets, field positions, reset values and counts for the
//          core wrapper test path.
// Assumes: Included by its bare name wherever the values are needed.
// Notes:   Definitions only.
`ifndef CTW_DEFINES_SVH
`define CTW_DEFINES_SVH

// Register offsets on the plain register port.
`define CTW_OFS_MODE 8'h00
`define CTW_OFS_VECTOR 8'h04
`define CTW_OFS_READ 8'h08
`define CTW_OFS_STATUS 8'h0c

// Field positions of the mode register.
`define CTW_MODE_TEST_BIT 0
`define CTW_MODE_STATE_LSB 1
`define CTW_MODE_STATE_MSB 2

// Reset values.
`define CTW_MODE_RESET 32'h0000_0000
`define CTW_VECTOR_RESET 18'h3_fffe

// Constant core inputs in every mode.
`define CTW_BUS_MODE_ENABLE 1'h0
`define CTW_DATA_BUS_ENABLE 1'h1
`define CTW_INPUT_ENABLE_N 1'h0

// Status register field positions.
`define CTW_STS_OE_LATCH 0
`define CTW_STS_TEST_MODE 1

// Synchroniser depth for pin inputs.
`define CTW_SYNC_STAGES 2

`endif

// *** pkg/ctw_pkg.sv ***
// Purpose: Types shared by the core wrapper test path.
// Assumes: Nothing beyond the standard language.
// Notes:   Control and status layouts match the core's bit order.
package ctw_pkg;

    // Core control inputs, bit 0 first from the bottom.
    typedef struct packed {
        logic trst_n;
        logic extern1;
        logic extern0;
        logic debug_request;
        logic breakpoint;
        logic debug_enable;
        logic sync_interrupts;
        logic big_endian;
        logic coproc_absent;
        logic coproc_busy;
        logic address_bus_enable;
        logic address_latch_enable;
        logic data_bus_enable;
        logic fiq_n;
        logic irq_n;
        logic abort;
        logic wait_n;
        logic core_reset_n;
    } ctw_core_ctrl_t;

    // Core status outputs as packed onto the read data.
    typedef struct packed {
        logic bus_disable_flag;
        logic [3:0] scan_chain_select;
        logic highz_instr;
        logic tdo_enable_n;
        logic debug_request_int;
        logic range_out0;
        logic range_out1;
        logic comm_rx;
        logic comm_tx;
        logic debug_ack;
        logic tdo;
        logic output_enable_n;
        logic core_output_enable_n_internal;
        logic compact_isa_state;
        logic coproc_instr_n;
        logic [4:0] mode_n;
        logic translate_n;
        logic executed_n;
        logic lock;
        logic [1:0] access_size;
        logic opcode_fetch_n;
        logic read_write_n;
        logic mem_request_n;
        logic sequential;
    } ctw_core_status_t;

    // Read-data selection, Gray along idle, data, address, status.
    typedef enum logic [1:0] {
        CTW_STATE_IDLE = 2'h0,
        CTW_STATE_CORE_DATA_READ = 2'h1,
        CTW_STATE_CORE_ADDRESS_READ = 2'h3,
        CTW_STATE_CORE_STATUS_READ = 2'h2
    } ctw_read_state_t;

    // Pins crossing in from outside the clock domain.
    typedef struct packed {
        logic trst_n;
        logic fiq_n;
        logic irq_n;
    } ctw_pins_t;

endpackage

// *** hw/ctw_clock_gate.sv ***
// Purpose: Memory clock gate with latched and test-mode enable terms.
// Assumes: Instantiated once by the wrapper top; clock cells are kept.
// Notes:   Inverted clock lets the test-term flop be written rising-edge only.
`timescale 1ns/1ns
`default_nettype none
module ctw_clock_gate (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Enables
    input wire logic clock_enable_in,
    input wire logic test_mode,
    input wire logic test_step,
    // Gated clock
    output logic memory_clock
);
    logic inverted_bus_clock;
    logic latched_clock_enable;
    logic test_mode_clock_enable;

    // Clock inverter feeding both enable terms.
    assign inverted_bus_clock = ~ref_clk;

    // Transparent while the bus clock is low, set on reset.
    always_latch begin
        if (!reset_n) begin
            latched_clock_enable = 1'b1;
        end else if (inverted_bus_clock) begin
            latched_clock_enable = clock_enable_in;
        end
    end

    // Test term on the inverted clock, rising edge only.
    always_ff @(posedge inverted_bus_clock or negedge reset_n) begin
        if (!reset_n) begin
            test_mode_clock_enable <= 1'b1;
        end else begin
            test_mode_clock_enable <= ~test_mode | test_step;
        end
    end

    // NAND gate; stays high while either term is off.
    assign memory_clock = ~(inverted_bus_clock & latched_clock_enable
                            & test_mode_clock_enable);
endmodule
`default_nettype wire

// *** hw/ctw_wrapper_top.sv ***
// Purpose: Test-access path and clock gating of a core bus wrapper.
// Assumes: One 20 MHz clock; test steps arrive as one-cycle enables.
// Notes:   The memory clock output is a gated clock, not a flop.
`timescale 1ns/1ns
`default_nettype none
`include "ctw_defines.svh"
module ctw_wrapper_top
    import ctw_pkg::*;
#(
    parameter bit TEST_BLOCK_PRESENT = 1'b1,
    parameter int ADDR_WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register port from the test controller
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Test step enable
    input wire logic test_step_clock,
    // Slave-side answer
    output logic slave_ready_out,
    output logic [1:0] slave_response_out,
    output logic [31:0] slave_read_data,
    // Core observation
    input wire logic [31:0] core_data_out,
    input wire logic [31:0] core_address,
    input wire ctw_core_status_t core_status,
    // Wrapper sources for normal mode
    input wire ctw_pins_t pins_async,
    input wire logic internal_abort,
    input wire logic core_wait_n,
    input wire logic core_reset_req_n,
    // Core control outputs
    output ctw_core_ctrl_t core_ctrl,
    output logic bus_mode_enable,
    output logic data_bus_enable_input,
    output logic core_input_enable_n,
    // Memory clock
    input wire logic memory_clock_enable,
    output logic memory_clock
);
    logic test_mode_q;
    ctw_read_state_t read_state_q;
    ctw_core_ctrl_t test_control_vector_q;
    ctw_core_ctrl_t default_ctrl;
    ctw_core_ctrl_t ctrl_d;
    ctw_core_status_t status_vector;
    ctw_pins_t pins_sync;
    logic oe_captured_q;
    logic test_mode_eff;
    logic test_step_eff;
    ctw_read_state_t read_state_eff;
    ctw_core_ctrl_t vector_eff;
    logic [31:0] read_mux_d;
    logic [31:0] reg_rdata_d;
    logic [`CTW_SYNC_STAGES-1:0] sync_q [3];

    // Two-stage synchronisers, one per pin.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync_q[gi] <= '1;
                end else begin
                    sync_q[gi] <= {sync_q[gi][0], pins_async[gi]};
                end
            end
            assign pins_sync[gi] = sync_q[gi][`CTW_SYNC_STAGES-1];
        end
    endgenerate

    // Mode and read-state register written by the test controller.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            test_mode_q <= 1'(`CTW_MODE_RESET);
            read_state_q <= CTW_STATE_IDLE;
        end else if (reg_write && reg_addr == `CTW_OFS_MODE) begin
            test_mode_q <= reg_wdata[`CTW_MODE_TEST_BIT];
            read_state_q <= ctw_read_state_t'(
                reg_wdata[`CTW_MODE_STATE_MSB:`CTW_MODE_STATE_LSB]);
        end
    end

    // Test vector applied to the core control inputs.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            test_control_vector_q <= `CTW_VECTOR_RESET;
        end else if (reg_write && reg_addr == `CTW_OFS_VECTOR) begin
            test_control_vector_q <= reg_wdata[17:0];
        end
    end

    // Without the test block every test input is static.
    always_comb begin
        if (TEST_BLOCK_PRESENT) begin
            test_mode_eff = test_mode_q;
            test_step_eff = test_step_clock;
            read_state_eff = read_state_q;
            vector_eff = test_control_vector_q;
        end else begin
            test_mode_eff = 1'b0;
            test_step_eff = 1'b0;
            read_state_eff = CTW_STATE_IDLE;
            vector_eff = `CTW_VECTOR_RESET;
        end
    end

    // Output enable is valid only in the access cycle, so hold it.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_captured_q <= 1'b1;
        end else if (test_step_eff) begin
            oe_captured_q <= core_status.core_output_enable_n_internal;
        end
    end

    // Fixed packing; the struct layout sets every bit position.
    always_comb begin
        status_vector = core_status;
        status_vector.core_output_enable_n_internal = oe_captured_q;
    end

    // Normal-mode sources: defaults or wrapper inputs.
    always_comb begin
        default_ctrl = '0;
        default_ctrl.trst_n = pins_sync.trst_n;
        default_ctrl.fiq_n = pins_sync.fiq_n;
        default_ctrl.irq_n = pins_sync.irq_n;
        default_ctrl.abort = internal_abort;
        default_ctrl.wait_n = core_wait_n;
        default_ctrl.core_reset_n = core_reset_req_n;
        default_ctrl.address_bus_enable = 1'b1;
        default_ctrl.coproc_absent = 1'b1;
        default_ctrl.coproc_busy = 1'b1;
        default_ctrl.address_latch_enable = 1'b1;
    end

    // Control multiplexer between test vector and defaults.
    always_comb begin
        if (test_mode_eff) begin
            ctrl_d = vector_eff;
            // State only advances while a step is applied.
            ctrl_d.wait_n = vector_eff.wait_n & test_step_eff;
        end else begin
            ctrl_d = default_ctrl;
        end
        ctrl_d.data_bus_enable = `CTW_DATA_BUS_ENABLE;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_ctrl <= `CTW_VECTOR_RESET;
        end else begin
            core_ctrl <= ctrl_d;
        end
    end

    // Constant enables; registered so outputs come from flops.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_mode_enable <= `CTW_BUS_MODE_ENABLE;
            data_bus_enable_input <= `CTW_DATA_BUS_ENABLE;
            core_input_enable_n <= `CTW_INPUT_ENABLE_N;
        end else begin
            bus_mode_enable <= `CTW_BUS_MODE_ENABLE;
            data_bus_enable_input <= `CTW_DATA_BUS_ENABLE;
            core_input_enable_n <= `CTW_INPUT_ENABLE_N;
        end
    end

    // Read-data multiplexer; zero outside test mode.
    always_comb begin
        read_mux_d = 32'h0000_0000;
        if (test_mode_eff) begin
            unique case (read_state_eff)
                CTW_STATE_IDLE: read_mux_d = 32'h0000_0000;
                CTW_STATE_CORE_DATA_READ: read_mux_d = core_data_out;
                CTW_STATE_CORE_ADDRESS_READ: read_mux_d = core_address;
                CTW_STATE_CORE_STATUS_READ: read_mux_d = status_vector;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            slave_read_data <= 32'h0000_0000;
        end else begin
            slave_read_data <= read_mux_d;
        end
    end

    // Never waits and never errors.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            slave_ready_out <= 1'b1;
            slave_response_out <= 2'h0;
        end else begin
            slave_ready_out <= 1'b1;
            slave_response_out <= 2'h0;
        end
    end

    // Register read decode; unmapped offsets read zero.
    always_comb begin
        reg_rdata_d = 32'h0000_0000;
        unique case (reg_addr)
            `CTW_OFS_MODE: begin
                reg_rdata_d[`CTW_MODE_TEST_BIT] = test_mode_q;
                reg_rdata_d[`CTW_MODE_STATE_MSB:`CTW_MODE_STATE_LSB] =
                    read_state_q;
            end
            `CTW_OFS_VECTOR: reg_rdata_d[17:0] = test_control_vector_q;
            `CTW_OFS_READ: reg_rdata_d = read_mux_d;
            `CTW_OFS_STATUS: begin
                reg_rdata_d[`CTW_STS_OE_LATCH] = oe_captured_q;
                reg_rdata_d[`CTW_STS_TEST_MODE] = test_mode_eff;
            end
            default: reg_rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            reg_rdata <= reg_rdata_d;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Gate is kept as one cell so synthesis cannot reshape it.
    ctw_clock_gate u_clock_gate (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clock_enable_in(memory_clock_enable),
        .test_mode(test_mode_eff),
        .test_step(test_step_eff),
        .memory_clock(memory_clock)
    );
endmodule
`default_nettype wire

// *** sim/ctw_wrapper_top_properties.sv ***
// Purpose: Port checker for the core wrapper test path.
// Assumes: Bound to the wrapper top; one clock domain.
// Notes:   Mode and vector are shadowed from register writes.
`timescale 1ns/1ns
`default_nettype none
`include "ctw_defines.svh"
module ctw_wrapper_checker
    import ctw_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    // Test and core side
    input wire logic test_step_clock,
    input wire logic slave_ready_out,
    input wire logic [1:0] slave_response_out,
    input wire logic [31:0] slave_read_data,
    input wire logic [31:0] core_data_out,
    input wire logic [31:0] core_address,
    input wire ctw_core_status_t core_status,
    input wire logic internal_abort,
    input wire logic core_wait_n,
    input wire ctw_core_ctrl_t core_ctrl,
    input wire logic bus_mode_enable,
    input wire logic data_bus_enable_input,
    input wire logic core_input_enable_n
);
    logic [2:0] mode_q;
    logic [17:0] vec_q;
    // Shadows let the checker know the mux choice without looking inside.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 3'h0;
        end else if (reg_write && reg_addr == `CTW_OFS_MODE) begin
            mode_q <= reg_wdata[2:0];
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            vec_q <= `CTW_VECTOR_RESET;
        end else if (reg_write && reg_addr == `CTW_OFS_VECTOR) begin
            vec_q <= reg_wdata[17:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_ready; slave_ready_out; endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    property p_resp; slave_response_out == 2'h0; endproperty
    a_resp: assert property (p_resp) else $error("resp not okay");
    property p_consts;
        {bus_mode_enable, data_bus_enable_input, core_input_enable_n,
         core_ctrl.data_bus_enable} == 4'h5;
    endproperty
    a_consts: assert property (p_consts) else $error("const bad");
    property p_off;
        reset_n && !mode_q[0] |=> slave_read_data == 32'h0;
    endproperty
    a_off: assert property (p_off) else $error("data out of mode");
    property p_idle; mode_q == 3'h1 |=> slave_read_data == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("idle not zero");
    property p_data;
        mode_q == 3'h3 |=> slave_read_data == $past(core_data_out);
    endproperty
    a_data: assert property (p_data) else $error("data sel");
    property p_addr;
        mode_q == 3'h7 |=> slave_read_data == $past(core_address);
    endproperty
    a_addr: assert property (p_addr) else $error("addr sel");
    property p_status;
        mode_q == 3'h5 |=> (slave_read_data & 32'hfffe_ffff) ==
            ($past(core_status) & 32'hfffe_ffff);
    endproperty
    a_status: assert property (p_status) else $error("stat");
    property p_vec;
        reset_n && mode_q[0] |=> core_ctrl.irq_n == $past(vec_q[3]) &&
            core_ctrl.wait_n == ($past(vec_q[1]) & $past(test_step_clock));
    endproperty
    a_vec: assert property (p_vec) else $error("vector not applied");
    property p_norm;
        reset_n && !mode_q[0] |=> core_ctrl.abort == $past(internal_abort)
            && core_ctrl.wait_n == $past(core_wait_n);
    endproperty
    a_norm: assert property (p_norm) else $error("normal mux bad");
    c_data: cover property (mode_q == 3'h3);
    c_status: cover property (mode_q == 3'h5);
    c_step: cover property (mode_q[0] && test_step_clock);
endmodule
bind ctw_wrapper_top ctw_wrapper_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write),
    .test_step_clock(test_step_clock), .slave_ready_out(slave_ready_out),
    .slave_response_out(slave_response_out),
    .slave_read_data(slave_read_data), .core_data_out(core_data_out),
    .core_address(core_address), .core_status(core_status),
    .internal_abort(internal_abort), .core_wait_n(core_wait_n),
    .core_ctrl(core_ctrl), .bus_mode_enable(bus_mode_enable),
    .data_bus_enable_input(data_bus_enable_input),
    .core_input_enable_n(core_input_enable_n)
);
`default_nettype wire

// *** sim/ctw_tic_model.sv ***
// Purpose: Test controller model driving the wrapper register port.
// Assumes: Strobes launched by non-blocking assignment after an edge.
// Notes:   Released lines are inverted so stale values never match.
`timescale 1ns/1ns
`default_nettype none
module ctw_test_ctrl_model #(
    parameter int ADDR_WIDTH = 8
) (
    // Clock
    input wire logic ref_clk,
    // Register port toward the wrapper
    output logic [ADDR_WIDTH-1:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [31:0] reg_rdata
);
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** sim/ctw_wrapper_top_tb.sv ***
// Purpose: Self-checking bench for the core wrapper test path.
// Assumes: Test block present; pins settle through a two-flop sync.
// Notes:   Output-enable bit 16 is masked where it is not the subject.
`timescale 1ns/1ns
`default_nettype none
`include "ctw_defines.svh"
`define CTW_CHK(a, e) \
    begin \
        compares++; \
        if ((a) !== (e)) begin \
            $display("mismatch at %0t got %h exp %h", $time, (a), (e)); \
            err_count++; \
        end \
    end
module ctw_wrapper_top_tb
    import ctw_pkg::*;
;
    logic ref_clk, reset_n, reg_write, reg_read, test_step_clock;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, slave_read_data, rd;
    logic [31:0] core_data_out, core_address;
    logic [1:0] slave_response_out;
    logic slave_ready_out, internal_abort, core_wait_n, core_reset_req_n;
    logic bus_mode_enable, data_bus_enable_input, core_input_enable_n;
    logic memory_clock_enable, memory_clock;
    ctw_core_status_t core_status;
    ctw_pins_t pins_async;
    ctw_core_ctrl_t core_ctrl;
    int err_count = 0;
    int compares = 0;
    logic [2:0] st [4] = '{3'h1, 3'h3, 3'h7, 3'h5};
    logic [31:0] ex [4] = '{32'h0, 32'h1234_5678, 32'h0abc_def0,
                            32'h8764_4321};
    ctw_wrapper_top i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .test_step_clock(test_step_clock),
        .slave_ready_out(slave_ready_out),
        .slave_response_out(slave_response_out),
        .slave_read_data(slave_read_data), .core_data_out(core_data_out),
        .core_address(core_address), .core_status(core_status),
        .pins_async(pins_async), .internal_abort(internal_abort),
        .core_wait_n(core_wait_n), .core_reset_req_n(core_reset_req_n),
        .core_ctrl(core_ctrl), .bus_mode_enable(bus_mode_enable),
        .data_bus_enable_input(data_bus_enable_input),
        .core_input_enable_n(core_input_enable_n),
        .memory_clock_enable(memory_clock_enable),
        .memory_clock(memory_clock)
    );
    ctw_test_ctrl_model i_ctl (
        .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
    );
    always #25 ref_clk = ~ref_clk;
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Capture happens on the edge that sees the step high.
    task automatic step_pulse;
        @(posedge ref_clk);
        test_step_clock <= 1'b1;
        @(posedge ref_clk);
        test_step_clock <= 1'b0;
        @(negedge ref_clk);
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end
    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        test_step_clock = 1'b0;
        core_data_out = 32'h1234_5678;
        core_address = 32'h0abc_def0;
        core_status = 32'h8765_4321;
        pins_async = 3'h5;
        internal_abort = 1'b1;
        core_wait_n = 1'b0;
        core_reset_req_n = 1'b1;
        memory_clock_enable = 1'b1;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        `CTW_CHK(slave_ready_out, 1'b1);
        `CTW_CHK(slave_response_out, 2'h0);
        `CTW_CHK(core_ctrl, 18'h3_fffe);
        #10 `CTW_CHK(memory_clock, 1'b0);
        @(posedge ref_clk);
        reset_n <= 1'b1;
        #10 `CTW_CHK(memory_clock, 1'b1);
        $display("test reset done");
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        `CTW_CHK(core_ctrl, 18'h2_03ed);
        `CTW_CHK(bus_mode_enable, 1'b0);
        `CTW_CHK(data_bus_enable_input, 1'b1);
        `CTW_CHK(core_input_enable_n, 1'b0);
        @(posedge ref_clk);
        pins_async <= 3'h2;
        internal_abort <= 1'b0;
        core_wait_n <= 1'b1;
        core_reset_req_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        `CTW_CHK(core_ctrl, 18'h0_03f2);
        `CTW_CHK(slave_read_data, 32'h0);
        i_ctl.read_reg(8'h10, rd);
        `CTW_CHK(rd, 32'h0);
        @(posedge ref_clk);
        memory_clock_enable <= 1'b0;
        @(negedge ref_clk);
        #10 `CTW_CHK(memory_clock, 1'b1);
        @(posedge ref_clk);
        memory_clock_enable <= 1'b1;
        @(negedge ref_clk);
        #10 `CTW_CHK(memory_clock, 1'b0);
        $display("test normal mode done");
        for (int i = 0; i < 4; i++) begin
            i_ctl.write_reg(`CTW_OFS_MODE, {29'h0, st[i]});
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            `CTW_CHK(slave_read_data & 32'hfffe_ffff, ex[i]);
            i_ctl.read_reg(`CTW_OFS_READ, rd);
            `CTW_CHK(rd & 32'hfffe_ffff, ex[i]);
        end
        $display("test read select done");
        i_ctl.write_reg(`CTW_OFS_VECTOR, 32'h0001_5a93);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        `CTW_CHK(core_ctrl, 18'h1_5ab1);
        #10 `CTW_CHK(memory_clock, 1'b1);
        step_pulse();
        `CTW_CHK(core_ctrl.wait_n, 1'b1);
        @(posedge ref_clk);
        core_status.core_output_enable_n_internal <= 1'b0;
        i_ctl.read_reg(`CTW_OFS_STATUS, rd);
        `CTW_CHK(rd[1:0], 2'h3);
        `CTW_CHK(slave_read_data[16], 1'b1);
        step_pulse();
        i_ctl.read_reg(`CTW_OFS_STATUS, rd);
        `CTW_CHK(rd[0], 1'b0);
        `CTW_CHK(slave_read_data[16], 1'b0);
        $display("test vector and capture done");
        i_ctl.write_reg(`CTW_OFS_MODE, 32'h0000_0004);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        `CTW_CHK(slave_read_data, 32'h0);
        $display("test mode exit done");
        complete_run();
    end
endmodule
`default_nettype wire
